// File: rtl/psm_map.vh
// Field layout, reset values and memory constants of the status word block
`ifndef PSM_MAP_VH
`define PSM_MAP_VH
`define PSM_W 32
`define PSM_ROM 31
`define PSM_PRE 30
`define PSM_KRN 29
`define PSM_PRV 28
`define PSM_PAR 27
`define PSM_PID_HI 26
`define PSM_PID_LO 19
`define PSM_RA_HI 18
`define PSM_RA_LO 17
`define PSM_RB_HI 16
`define PSM_RB_LO 15
`define PSM_IMP 14
`define PSM_DMP 13
`define PSM_EXT 12
`define PSM_ILL 11
`define PSM_ITF 10
`define PSM_DTF 9
`define PSM_WPV 8
`define PSM_COP 7
`define PSM_USR 6
`define PSM_LIT_HI 5
`define PSM_LIT_LO 0
`define PSM_RST_VALUE 32'he800_6000
`define PSM_WR_MASK 32'hffff_e000
`define PSM_BOOT_LIMIT 32'h0002_0000
`define PSM_PID_SCALE 2
`endif

// File: rtl/psm_tb_hash.v
// Translation buffer index hash from low page number and process id
`include "psm_map.vh"
module psm_tb_hash (
  input wire i_core_clk, // System clock
  input wire i_sys_rst, // Synchronous reset
  input wire [7:0] i_low_page, // Low page number field
  input wire [7:0] i_pid, // Current process id
  output reg [7:0] o_index // Hashed index, modulo 256
);
  wire [7:0] pid_x4;
  wire [7:0] next_index;
  assign pid_x4 = {i_pid[7-`PSM_PID_SCALE:0], {`PSM_PID_SCALE{1'b0}}};
  assign next_index = i_low_page + pid_x4;

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_index <= 8'h00;
    end else begin
      o_index <= next_index;
    end
  end
endmodule // psm_tb_hash

// File: rtl/psm_boot_map.v
// Routes memory references between main memory and the boot store
`include "psm_map.vh"
module psm_boot_map (
  input wire i_core_clk, // System clock
  input wire i_sys_rst, // Synchronous reset
  input wire i_rom_map, // Boot mapping bit
  input wire i_req, // Reference request, one cycle
  input wire i_we, // Reference is a write
  input wire [31:0] i_addr, // Real byte address
  output reg o_rom_rd, // Read served from boot store
  output reg o_ram_rd, // Read served from main memory
  output reg o_ram_wr, // Write to main memory
  output reg [31:0] o_addr // Address forwarded
);
  wire low_region;
  assign low_region = (i_addr < `PSM_BOOT_LIMIT);

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_rom_rd <= 1'b0;
      o_ram_rd <= 1'b0;
      o_ram_wr <= 1'b0;
      o_addr <= 32'h0000_0000;
    end else begin
      o_rom_rd <= i_req & ~i_we & i_rom_map & low_region;
      o_ram_rd <= i_req & ~i_we & ~(i_rom_map & low_region);
      o_ram_wr <= i_req & i_we;
      o_addr <= i_addr;
    end
  end
endmodule // psm_boot_map

// File: rtl/psm_core.v
// Status word, privilege mode control, register bank and memory routing
`include "psm_map.vh"
module psm_core (
  input wire i_core_clk, // System clock, 20 MHz
  input wire i_sys_rst, // Synchronous reset, active high
  input wire i_psw_wr, // Status word write instruction
  input wire [31:0] i_psw_wdata, // Status word write data
  input wire i_psw_rd, // Status word read instruction
  input wire i_priv_op, // Other privileged instruction issued
  input wire i_bad_op, // Abort or undefined instruction issued
  input wire i_mark_ro, // Request to mark a page read-only
  input wire i_usr_trap, // User trap instruction issued
  input wire [5:0] i_usr_lit, // Literal of user trap instruction
  input wire i_ext_irq, // Memory controller interrupt
  input wire i_cop_irq, // Coprocessor trap or timer interrupt
  input wire i_itf, // Instruction translation fault
  input wire i_dtf, // Data translation fault
  input wire i_wpv, // Store to read-only page
  input wire [5:0] i_reg_a, // Instruction ra/rc register field
  input wire [5:0] i_reg_b, // Instruction rb register field
  input wire [7:0] i_low_page, // Low page field of virtual address
  input wire i_mem_req, // Memory reference request
  input wire i_mem_we, // Memory reference is a write
  input wire [31:0] i_mem_addr, // Real byte address of reference
  output reg [31:0] o_psw_rdata, // Status word read data
  output reg o_psw_rvalid, // Read data valid, one cycle
  output reg o_kernel, // Kernel mode
  output reg o_priv_ok, // Privileged instructions permitted
  output reg o_trap, // Trap taken, one cycle
  output reg o_parity_en, // Parity checking active
  output reg o_ro_mark_wr, // Read-only mark accepted, one cycle
  output reg [7:0] o_reg_addr_a, // Register file address, port a
  output reg [7:0] o_reg_addr_b, // Register file address, port b
  output reg o_imap_off, // Instruction translation bypassed
  output reg o_dmap_off, // Data translation bypassed
  output reg [7:0] o_tb_pid, // Process tag for translation entries
  output wire [7:0] o_tb_index, // Translation buffer index
  output wire o_rom_rd, // Read from boot store
  output wire o_ram_rd, // Read from main memory
  output wire o_ram_wr, // Write to main memory
  output wire [31:0] o_mem_addr // Forwarded memory address
);
  // Status word fields
  reg rom;
  reg pre;
  reg krn;
  reg prv;
  reg par;
  reg [7:0] pid;
  reg [1:0] ra;
  reg [1:0] rb;
  reg imp;
  reg dmp;
  reg [6:0] cause;
  reg [5:0] literal;

  wire [31:0] program_status_word;
  wire allowed;
  wire illegal;
  wire [6:0] live_cause;
  wire trap_now;
  wire wr_ok;
  wire rd_ok;
  wire [31:0] rst_word;

  reg next_rom;
  reg next_pre;
  reg next_prv;
  reg next_par;
  reg [7:0] next_pid;
  reg [1:0] next_ra;
  reg [1:0] next_rb;
  reg next_imp;
  reg next_dmp;

  // Assemble the 32-bit word
  assign program_status_word = {rom, pre, krn, prv, par, pid, ra, rb, imp, dmp,
                cause, literal};

  // Privilege is granted in kernel mode or with the enable bit
  assign allowed = krn | prv;

  // Privileged accesses without permission raise the illegal cause
  assign illegal = ~krn & (((i_priv_op | i_psw_wr | i_psw_rd | i_mark_ro) & ~prv)
                   | i_bad_op);

  // Interrupts are masked away while in kernel mode
  assign live_cause = {i_ext_irq & ~krn,
                       illegal,
                       i_itf,
                       i_dtf,
                       i_wpv,
                       i_cop_irq & ~krn,
                       i_usr_trap};

  // Traps are taken only from user mode
  assign trap_now = ~krn & (|live_cause);

  assign wr_ok = i_psw_wr & allowed;
  assign rd_ok = i_psw_rd & allowed;
  assign rst_word = `PSM_RST_VALUE;

  // Writable fields, then trap overrides
  always @* begin
    next_rom = rom;
    next_pre = pre;
    next_prv = prv;
    next_par = par;
    next_pid = pid;
    next_ra = ra;
    next_rb = rb;
    next_imp = imp;
    next_dmp = dmp;
    if (wr_ok) begin
      next_rom = i_psw_wdata[`PSM_ROM];
      next_pre = i_psw_wdata[`PSM_PRE];
      next_prv = i_psw_wdata[`PSM_PRV];
      next_par = i_psw_wdata[`PSM_PAR];
      next_pid = i_psw_wdata[`PSM_PID_HI:`PSM_PID_LO];
      next_ra = i_psw_wdata[`PSM_RA_HI:`PSM_RA_LO];
      next_rb = i_psw_wdata[`PSM_RB_HI:`PSM_RB_LO];
      next_imp = i_psw_wdata[`PSM_IMP];
      next_dmp = i_psw_wdata[`PSM_DMP];
    end
    if (trap_now) begin
      next_pre = 1'b1;
      next_imp = 1'b1;
      next_dmp = 1'b1;
    end
  end

  // Status word register, one process per field
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rom <= rst_word[`PSM_ROM];
    end else begin
      rom <= next_rom;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pre <= rst_word[`PSM_PRE];
    end else begin
      pre <= next_pre;
    end
  end

  // Kernel bit shadows the pre-kernel bit, writes never reach it
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      krn <= rst_word[`PSM_KRN];
    end else begin
      krn <= trap_now ? 1'b1 : pre;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      prv <= rst_word[`PSM_PRV];
    end else begin
      prv <= next_prv;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      par <= rst_word[`PSM_PAR];
    end else begin
      par <= next_par;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pid <= rst_word[`PSM_PID_HI:`PSM_PID_LO];
    end else begin
      pid <= next_pid;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ra <= rst_word[`PSM_RA_HI:`PSM_RA_LO];
    end else begin
      ra <= next_ra;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rb <= rst_word[`PSM_RB_HI:`PSM_RB_LO];
    end else begin
      rb <= next_rb;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      imp <= rst_word[`PSM_IMP];
    end else begin
      imp <= next_imp;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      dmp <= rst_word[`PSM_DMP];
    end else begin
      dmp <= next_dmp;
    end
  end

  // Cause and literal follow the pipeline only in user mode
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      cause <= rst_word[`PSM_EXT:`PSM_USR];
    end else if (~krn) begin
      cause <= live_cause;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      literal <= rst_word[`PSM_LIT_HI:`PSM_LIT_LO];
    end else if (~krn) begin
      literal <= i_usr_lit;
    end
  end

  // Registered outputs
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_psw_rdata <= 32'h0000_0000;
    end else begin
      o_psw_rdata <= rd_ok ? program_status_word : 32'h0000_0000;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_psw_rvalid <= 1'b0;
    end else begin
      o_psw_rvalid <= rd_ok;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_kernel <= rst_word[`PSM_KRN];
    end else begin
      o_kernel <= trap_now ? 1'b1 : pre;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_priv_ok <= rst_word[`PSM_KRN] | rst_word[`PSM_PRV];
    end else begin
      o_priv_ok <= (trap_now ? 1'b1 : pre) | next_prv;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_trap <= 1'b0;
    end else begin
      o_trap <= trap_now;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_parity_en <= ~rst_word[`PSM_PAR];
    end else begin
      o_parity_en <= ~next_par;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_ro_mark_wr <= 1'b0;
    end else begin
      o_ro_mark_wr <= i_mark_ro & allowed;
    end
  end

  // Bank selects the upper address bits of 64-entry windows
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_reg_addr_a <= 8'h00;
    end else begin
      o_reg_addr_a <= {next_ra, i_reg_a};
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_reg_addr_b <= 8'h00;
    end else begin
      o_reg_addr_b <= {next_rb, i_reg_b};
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_imap_off <= rst_word[`PSM_IMP];
    end else begin
      o_imap_off <= next_imp;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_dmap_off <= rst_word[`PSM_DMP];
    end else begin
      o_dmap_off <= next_dmp;
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_tb_pid <= rst_word[`PSM_PID_HI:`PSM_PID_LO];
    end else begin
      o_tb_pid <= next_pid;
    end
  end

  psm_tb_hash u_hash (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_low_page(i_low_page),
    .i_pid(pid),
    .o_index(o_tb_index)
  );

  // Requester keeps boot-store references non-overlapped
  psm_boot_map u_boot (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_rom_map(rom),
    .i_req(i_mem_req),
    .i_we(i_mem_we),
    .i_addr(i_mem_addr),
    .o_rom_rd(o_rom_rd),
    .o_ram_rd(o_ram_rd),
    .o_ram_wr(o_ram_wr),
    .o_addr(o_mem_addr)
  );
endmodule // psm_core

// File: tb/psm_core_props.sv
// Port-level assertions for the status word block
module psm_core_props (
  input wire i_core_clk, // Clock
  input wire i_sys_rst, // Reset
  input wire i_psw_wr, // Word write
  input wire [31:0] i_psw_wdata, // Write data
  input wire i_psw_rd, // Word read
  input wire i_mark_ro, // Mark request
  input wire i_usr_trap, // User trap
  input wire i_mem_req, // Mem request
  input wire i_mem_we, // Mem write
  input wire [31:0] i_mem_addr, // Mem address
  input wire o_psw_rvalid, // Read valid
  input wire o_kernel, // Kernel mode
  input wire o_priv_ok, // Privilege on
  input wire o_trap, // Trap pulse
  input wire o_parity_en, // Parity on
  input wire o_ro_mark_wr, // Mark accepted
  input wire o_imap_off, // I bypass
  input wire o_dmap_off, // D bypass
  input wire o_rom_rd, // Boot read
  input wire o_ram_rd, // Ram read
  input wire o_ram_wr, // Ram write
  input wire [31:0] o_mem_addr // Fwd address
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  rst_state_a: assert property ($fell(i_sys_rst) |-> o_kernel && o_priv_ok
    && !o_parity_en && o_imap_off && o_dmap_off) else $error("reset state wrong");
  trap_entry_a: assert property (!o_kernel && i_usr_trap |=> o_trap && o_kernel
    && o_imap_off && o_dmap_off) else $error("user trap entry wrong");
  krn_mask_a: assert property (o_kernel |=> !o_trap) else $error("trap in kernel");
  pre_shadow_a: assert property (o_kernel && i_psw_wr && !i_psw_wdata[30]
    |=> o_kernel ##1 !o_kernel) else $error("kernel bit not following pre");
  krn_ro_a: assert property (o_kernel && i_psw_wr && i_psw_wdata[30]
    |=> o_kernel [*2]) else $error("kernel bit changed by write");
  rd_grant_a: assert property (i_psw_rd && o_priv_ok |=> o_psw_rvalid)
    else $error("privileged read not answered");
  rd_refuse_a: assert property (i_psw_rd && !o_priv_ok
    |=> !o_psw_rvalid ##[0:1] o_trap) else $error("user read not refused");
  wr_ram_a: assert property (i_mem_req && i_mem_we |=> o_ram_wr && !o_rom_rd
    && !o_ram_rd && o_mem_addr == $past(i_mem_addr)) else $error("write misrouted");
  high_ram_a: assert property (i_mem_req && !i_mem_we && i_mem_addr >= 32'h0002_0000
    |=> o_ram_rd && !o_rom_rd) else $error("high read misrouted");
  ro_priv_a: assert property (i_mark_ro |=> o_ro_mark_wr == $past(o_priv_ok))
    else $error("read-only mark privilege wrong");
  cover property (o_trap);
  cover property (o_rom_rd);
  cover property (o_psw_rvalid);
endmodule // psm_core_props

bind psm_core psm_core_props psm_core_props_inst (.*);

// File: tb/psm_mem_model.sv
// Memory controller and boot store stand-in: counts boot store reads, flags overlapped references
module psm_mem_model (
  input wire logic i_core_clk, // Clock
  input wire logic i_sys_rst, // Reset, clears the counts
  input wire logic i_rom_rd, // Boot store read
  input wire logic i_ram_rd, // Main memory read
  input wire logic i_ram_wr, // Main memory write
  output int o_rom_reads, // Boot reads seen
  output logic o_clash // Overlapped references seen
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_rom_reads <= 0;
      o_clash <= 1'h0;
    end else begin
      if (i_rom_rd) o_rom_reads <= o_rom_reads + 1;
      if (int'(i_rom_rd) + int'(i_ram_rd) + int'(i_ram_wr) > 1) o_clash <= 1'h1;
    end
  end
endmodule // psm_mem_model

// File: tb/psm_core_tb.sv
// Self-checking bench for the status word and boot routing block
module psm_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_core_clk = 1'h0, i_sys_rst = 1'h1, i_psw_wr = 1'h0, i_psw_rd = 1'h0;
  logic i_mark_ro = 1'h0, i_usr_trap = 1'h0, i_ext_irq = 1'h0, i_cop_irq = 1'h0;
  logic i_mem_req = 1'h0, i_mem_we = 1'h0, o_psw_rvalid, o_kernel, o_priv_ok, o_trap;
  logic o_parity_en, o_ro_mark_wr, o_imap_off, o_dmap_off, o_rom_rd, o_ram_rd, o_ram_wr;
  logic clash;
  logic i_priv_op = 1'h0, i_bad_op = 1'h0, i_itf = 1'h0, i_dtf = 1'h0, i_wpv = 1'h0;
  logic [31:0] i_psw_wdata = 32'h0, i_mem_addr = 32'h0, o_psw_rdata, o_mem_addr;
  logic [5:0] i_usr_lit = 6'h0, i_reg_a = 6'h0, i_reg_b = 6'h0;
  logic [7:0] i_low_page = 8'h0, o_reg_addr_a, o_reg_addr_b, o_tb_pid, o_tb_index;
  int mismatches = 0, tests_run = 0, rom_reads, k;
  always #25 i_core_clk = ~i_core_clk;
  psm_core psm_core_inst (.*);
  psm_mem_model psm_mem_model_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_rom_rd(o_rom_rd),
    .i_ram_rd(o_ram_rd), .i_ram_wr(o_ram_wr), .o_rom_reads(rom_reads), .o_clash(clash));
  task automatic tick;
    @(negedge i_core_clk);
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(logic [31:0] d);
    i_psw_wr = 1'h1;
    i_psw_wdata = d;
    tick;
    i_psw_wr = 1'h0;
    repeat (2) tick;
  endtask
  // Literal is only meaningful while the user trap flag is set
  task automatic rd(logic [31:0] e);
    i_psw_rd = 1'h1;
    tick;
    i_psw_rd = 1'h0;
    chk("rvalid", o_psw_rvalid, 1'h1);
    chk("psw", o_psw_rdata & {26'h3ff_ffff, {6{e[6]}}}, e);
  endtask
  task automatic mem(logic we, logic [31:0] a, logic [2:0] e);
    i_mem_req = 1'h1;
    i_mem_we = we;
    i_mem_addr = a;
    tick;
    i_mem_req = 1'h0;
    chk("route", {o_rom_rd, o_ram_rd, o_ram_wr}, e);
    chk("fwd_addr", o_mem_addr, a);
    tick;
  endtask
  task automatic wait_trap;
    k = 0;
    while (o_trap !== 1'h1 && k < 20) begin
      tick;
      k++;
    end
    chk("trap", o_trap, 1'h1);
    if (k == 20) complete_run;
  endtask
  initial begin
    repeat (3) tick;
    i_sys_rst = 1'h0;
    tick;
    chk("kernel", o_kernel, 1'h1);
    chk("priv", o_priv_ok, 1'h1);
    chk("parity", o_parity_en, 1'h0);
    rd(32'he800_6000);
    i_mark_ro = 1'h1;
    tick;
    i_mark_ro = 1'h0;
    chk("ro_mark", o_ro_mark_wr, 1'h1);
    i_ext_irq = 1'h1;
    repeat (2) tick;
    rd(32'he800_6000);
    i_ext_irq = 1'h0;
    $display("test reset done");
    i_reg_a = 6'h3f;
    i_reg_b = 6'h01;
    i_low_page = 8'hfe;
    wr(32'hc02d_e000);
    rd(32'he02d_e000);
    chk("bank_a", o_reg_addr_a, 8'hbf);
    chk("bank_b", o_reg_addr_b, 8'hc1);
    chk("pid_tag", o_tb_pid, 8'h05);
    chk("tb_index", o_tb_index, 8'h12);
    chk("parity", o_parity_en, 1'h1);
    $display("test fields done");
    mem(1'h0, 32'h0000_1000, 3'h4);
    mem(1'h1, 32'h0000_1000, 3'h1);
    mem(1'h0, 32'h0001_fffc, 3'h4);
    mem(1'h0, 32'h0002_0000, 3'h2);
    wr(32'h402d_e000);
    mem(1'h0, 32'h0000_1000, 3'h2);
    chk("rom_reads", rom_reads, 32'h2);
    chk("clash", clash, 1'h0);
    $display("test boot map done");
    wr(32'h002d_e000);
    chk("user", o_kernel, 1'h0);
    chk("no_priv", o_priv_ok, 1'h0);
    i_psw_rd = 1'h1;
    tick;
    i_psw_rd = 1'h0;
    chk("refused", o_psw_rvalid, 1'h0);
    chk("refused_data", o_psw_rdata, 32'h0);
    wait_trap;
    rd(32'h602d_e800);
    $display("test refusal done");
    wr(32'h002d_e000);
    i_usr_lit = 6'h2a;
    i_usr_trap = 1'h1;
    tick;
    i_usr_trap = 1'h0;
    wait_trap;
    rd(32'h602d_e06a);
    $display("test user trap done");
    wr(32'h102d_e000);
    chk("priv", o_priv_ok, 1'h1);
    rd(32'h102d_e000);
    i_cop_irq = 1'h1;
    wait_trap;
    i_cop_irq = 1'h0;
    rd(32'h702d_e080);
    $display("test priv enable done");
    wr(32'h102d_e000);
    i_priv_op = 1'h1;
    i_itf = 1'h1;
    i_wpv = 1'h1;
    tick;
    i_priv_op = 1'h0;
    i_itf = 1'h0;
    i_wpv = 1'h0;
    wait_trap;
    rd(32'h702d_e500);
    wr(32'h002d_e000);
    i_bad_op = 1'h1;
    i_dtf = 1'h1;
    i_mark_ro = 1'h1;
    tick;
    i_bad_op = 1'h0;
    i_dtf = 1'h0;
    i_mark_ro = 1'h0;
    chk("ro_refused", o_ro_mark_wr, 1'h0);
    wait_trap;
    rd(32'h602d_ea00);
    $display("test fault causes done");
    i_sys_rst = 1'h1;
    repeat (3) tick;
    i_sys_rst = 1'h0;
    tick;
    chk("kernel", o_kernel, 1'h1);
    chk("parity", o_parity_en, 1'h0);
    rd(32'he800_6000);
    mem(1'h0, 32'h0001_0000, 3'h4);
    chk("rom_reads", rom_reads, 32'h1);
    chk("clash", clash, 1'h0);
    $display("test mid reset done");
    complete_run;
  end
endmodule // psm_core_tb
